// File: burst_addr_step.sv
/*
  Next register address for a burst read. With the queue off the
  status and result bytes wrap 05h back to 00h; with the queue on the
  data port at 01h repeats so a burst drains the queue.
  Assumes a purely combinational use by the register port.
*/
`default_nettype none

module burst_addr_step (
  // Address in
  input  wire logic [7:0] curAddr,
  input  wire logic       queueOn,
  // Address out
  output logic      [7:0] nextAddr
);

  always_comb begin
    if (curAddr == sample_status_pkg::ADDR_BURST_WRAP) begin
      nextAddr = sample_status_pkg::ADDR_STATUS_ALIAS;
    end else if (queueOn && (curAddr == sample_status_pkg::ADDR_PRESS_HI)) begin
      nextAddr = sample_status_pkg::ADDR_PRESS_HI;
    end else begin
      nextAddr = 8'(curAddr + 8'h01);
    end
  end

endmodule

`default_nettype wire

// File: host_reader.sv
/*
  Host-side reader of the register port: loads a start address, then
  strobes one read per byte and keeps every byte that comes back.
  Assumes the one-cycle registered read answer of the status block.
*/
`default_nettype none

module host_reader (
  // Clock
  input  wire logic       clock,
  // Register read port
  output logic            addrLoad,
  output logic      [7:0] addrIn,
  output logic            rdStrobe,
  input  wire logic [7:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] got [0:7];

  initial begin
    addrLoad = 1'b0;
    addrIn   = 8'h00;
    rdStrobe = 1'b0;
  end

  // Strobe held every cycle; pointer loaded on the first byte only
  task automatic burst(input logic [7:0] a, input int n);
    @(posedge clock);
    addrLoad <= 1'b1;
    addrIn   <= a;
    rdStrobe <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      addrLoad <= 1'b0;
      // Stale address would hide a missed pointer load
      addrIn   <= ~a;
      if (i == n - 1) rdStrobe <= 1'b0;
      #1 got[i] = rdData;
    end
  endtask
endmodule

`default_nettype wire

// File: sample_status_flags.sv
/*
  Per-sample status logic: ready and overwrite flags for pressure or
  altitude and temperature results, the result bytes, the status alias
  at 00h and the burst address pointer.
  Assumes an I2C engine on the same clock that loads a start address
  and pulses a read strobe per byte, and an acquisition engine that
  pulses a done strobe with its sample. Queue storage lives elsewhere.
*/
// Notes on behaviour
// - 00h reads sample status or queue status
// - Burst reads advance through status and data
// - Status bit layout fixed; reset zero, read-only
// - Any overwrite set on unread result replaced
// - Any overwrite cleared by high-byte or queue read
// - Pressure overwrite set when unread result replaced
// - Pressure overwrite cleared by pressure-high or queue read
// - Temperature overwrite set when unread result replaced
// - Temperature overwrite cleared by temp-high or queue read
// - Any ready set on new result, cleared likewise
// - Pressure ready set per acquisition, cleared on read
// - Temperature ready set per acquisition, cleared on read
// - Combined flags need ready event generator enable
// - Pressure flags need pressure event enable
// - Temperature flags need temperature event enable
// - Queue off: result bytes show real-time sample
// - Queue field: 00 off, 01 circular, 10 stop
// - Altimeter mode stores altitude, else pressure
`default_nettype none

module sample_status_flags (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Register read port
  input  wire logic        addrLoad,
  input  wire logic [7:0]  addrIn,
  input  wire logic        rdStrobe,
  output logic      [7:0]  rdData,
  output logic      [7:0]  curAddr,
  // Acquisition results
  input  wire logic        pressDone,
  input  wire logic        tempDone,
  input  wire logic [19:0] pressureSample,
  input  wire logic [19:0] altitudeSample,
  input  wire logic [11:0] tempSample,
  // Configuration bits
  input  wire logic [1:0]  queueModeField,
  input  wire logic        altimeterMode,
  input  wire logic        readyEventGenEnable,
  input  wire logic        pressEventEnable,
  input  wire logic        tempEventEnable,
  // Queue port
  input  wire logic [7:0]  queueStatus,
  input  wire logic [7:0]  queueData,
  output logic             queuePop,
  // Status view
  output logic      [7:0]  sampleReadyStatus,
  output logic             queueOn
);

  typedef struct packed {
    logic [7:0]  rdData;
    logic [7:0]  addrPtr;
    logic [19:0] pressRes;
    logic [11:0] tempRes;
  } state_t;

  state_t                          st_r;
  state_t                          st_nxt;
  sample_status_pkg::queue_mode_t  qMode;
  logic [7:0]                      effAddr;
  logic [7:0]                      stepAddr;
  logic [7:0]                      readByte;
  logic [7:0]                      status;
  logic [7:0]                      setVec;
  logic [7:0]                      clrVec;
  logic                            pressHiRead;
  logic                            tempHiRead;
  logic                            queueRead;
  logic                            pressClr;
  logic                            tempClr;
  logic                            anyClr;
  logic                            pressSet;
  logic                            tempSet;
  logic                            anySet;

  always_comb begin
    case (queueModeField)
      sample_status_pkg::QFIELD_OFF:       qMode = sample_status_pkg::QM_OFF;
      sample_status_pkg::QFIELD_CIRCULAR:  qMode = sample_status_pkg::QM_CIRCULAR;
      sample_status_pkg::QFIELD_STOP_FULL: qMode = sample_status_pkg::QM_STOP_FULL;
      default:                             qMode = sample_status_pkg::QM_RESERVED;
    endcase
  end

  // Reserved code treated as queue on, as any nonzero field
  assign queueOn = (qMode != sample_status_pkg::QM_OFF);

  // A load in the same cycle as a read reads at the new address
  assign effAddr = addrLoad ? addrIn : st_r.addrPtr;

  burst_addr_step u_step (
    .curAddr  (effAddr),
    .queueOn  (queueOn),
    .nextAddr (stepAddr)
  );

  // Read qualifiers that retire results
  assign pressHiRead = rdStrobe && !queueOn && (effAddr == sample_status_pkg::ADDR_PRESS_HI);
  assign tempHiRead  = rdStrobe && !queueOn && (effAddr == sample_status_pkg::ADDR_TEMP_HI);
  assign queueRead   = rdStrobe && queueOn &&
                       ((effAddr == sample_status_pkg::ADDR_PRESS_HI) ||
                        (effAddr == sample_status_pkg::ADDR_QUEUE_DATA));
  assign queuePop    = queueRead;

  assign pressClr = pressHiRead || queueRead;
  assign tempClr  = tempHiRead || queueRead;
  assign anyClr   = pressHiRead || tempHiRead || queueRead;

  assign pressSet = pressDone && pressEventEnable;
  assign tempSet  = tempDone && tempEventEnable;
  assign anySet   = (pressDone || tempDone) && readyEventGenEnable;

  // Overwrite only counts if the old result was not retired this cycle
  always_comb begin
    setVec = 8'h00;
    clrVec = 8'h00;
    setVec[sample_status_pkg::BIT_PRESS_READY] = pressSet;
    clrVec[sample_status_pkg::BIT_PRESS_READY] = pressClr;
    setVec[sample_status_pkg::BIT_TEMP_READY] = tempSet;
    clrVec[sample_status_pkg::BIT_TEMP_READY] = tempClr;
    setVec[sample_status_pkg::BIT_ANY_READY] = anySet;
    clrVec[sample_status_pkg::BIT_ANY_READY] = anyClr;
    setVec[sample_status_pkg::BIT_PRESS_OVERWRITE] =
      pressSet && status[sample_status_pkg::BIT_PRESS_READY] && !pressClr;
    clrVec[sample_status_pkg::BIT_PRESS_OVERWRITE] = pressClr;
    setVec[sample_status_pkg::BIT_TEMP_OVERWRITE] =
      tempSet && status[sample_status_pkg::BIT_TEMP_READY] && !tempClr;
    clrVec[sample_status_pkg::BIT_TEMP_OVERWRITE] = tempClr;
    setVec[sample_status_pkg::BIT_ANY_OVERWRITE] =
      anySet && status[sample_status_pkg::BIT_ANY_READY] && !anyClr;
    clrVec[sample_status_pkg::BIT_ANY_OVERWRITE] = anyClr;
  end

  // status flops, reserved bits never set
  status_flag_bank #(
    .WIDTH (8)
  ) u_flags (
    .clock   (clock),
    .sys_rst (sys_rst),
    .setVec  (setVec & sample_status_pkg::STATUS_USED_MASK),
    .clrVec  (clrVec),
    .flags   (status)
  );

  always_comb begin
    case (effAddr)
      sample_status_pkg::ADDR_STATUS_ALIAS: begin
        readByte = queueOn ? queueStatus : status;
      end
      sample_status_pkg::ADDR_PRESS_HI: begin
        readByte = queueOn ? queueData : st_r.pressRes[19:12];
      end
      sample_status_pkg::ADDR_PRESS_MID: begin
        readByte = queueOn ? sample_status_pkg::UNMAPPED_VALUE : st_r.pressRes[11:4];
      end
      sample_status_pkg::ADDR_PRESS_LO: begin
        readByte = queueOn ? sample_status_pkg::UNMAPPED_VALUE : {st_r.pressRes[3:0], 4'h0};
      end
      sample_status_pkg::ADDR_TEMP_HI: begin
        readByte = queueOn ? sample_status_pkg::UNMAPPED_VALUE : st_r.tempRes[11:4];
      end
      sample_status_pkg::ADDR_TEMP_LO: begin
        readByte = queueOn ? sample_status_pkg::UNMAPPED_VALUE : {st_r.tempRes[3:0], 4'h0};
      end
      // reserved bits already zero in the flops
      sample_status_pkg::ADDR_SAMPLE_READY: readByte = status;
      sample_status_pkg::ADDR_QUEUE_STATUS: readByte = queueStatus;
      sample_status_pkg::ADDR_QUEUE_DATA:   readByte = queueData;
      default:                              readByte = sample_status_pkg::UNMAPPED_VALUE;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (rdStrobe) begin
      st_nxt.rdData  = readByte;
      st_nxt.addrPtr = stepAddr;
    end else if (addrLoad) begin
      st_nxt.addrPtr = addrIn;
    end
    if (pressDone) begin
      st_nxt.pressRes = altimeterMode ? altitudeSample : pressureSample;
    end
    if (tempDone) begin
      st_nxt.tempRes = tempSample;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.rdData   <= sample_status_pkg::RDDATA_RESET;
      st_r.addrPtr  <= sample_status_pkg::ADDR_RESET;
      st_r.pressRes <= sample_status_pkg::PRESS_RESET;
      st_r.tempRes  <= sample_status_pkg::TEMP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData            = st_r.rdData;
  assign curAddr           = st_r.addrPtr;
  assign sampleReadyStatus = status;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  property p_alias_ready;
    rdStrobe && !queueOn && (effAddr == sample_status_pkg::ADDR_STATUS_ALIAS)
      |=> rdData == $past(status);
  endproperty
  a_alias_ready: assert property (p_alias_ready)
    else $error("Alias did not return sample status");

  property p_alias_queue;
    rdStrobe && queueOn && (effAddr == sample_status_pkg::ADDR_STATUS_ALIAS)
      |=> rdData == $past(queueStatus);
  endproperty
  a_alias_queue: assert property (p_alias_queue)
    else $error("Alias did not return queue status");

  property p_burst_wrap;
    rdStrobe && (effAddr == sample_status_pkg::ADDR_TEMP_LO)
      |=> curAddr == sample_status_pkg::ADDR_STATUS_ALIAS;
  endproperty
  a_burst_wrap: assert property (p_burst_wrap)
    else $error("Burst did not wrap to status");

  property p_burst_next;
    rdStrobe && !queueOn && (effAddr == sample_status_pkg::ADDR_STATUS_ALIAS)
      |=> curAddr == sample_status_pkg::ADDR_PRESS_HI;
  endproperty
  a_burst_next: assert property (p_burst_next)
    else $error("Burst did not advance past status");

  property p_reserved_zero;
    (sampleReadyStatus & ~sample_status_pkg::STATUS_USED_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved status bit set");

  property p_any_ow_set;
    anySet && status[sample_status_pkg::BIT_ANY_READY] && !anyClr
      |=> status[sample_status_pkg::BIT_ANY_OVERWRITE];
  endproperty
  a_any_ow_set: assert property (p_any_ow_set)
    else $error("Combined overwrite not set");

  property p_any_clr;
    (pressHiRead || queueRead) && !anySet
      |=> !status[sample_status_pkg::BIT_ANY_OVERWRITE] &&
          !status[sample_status_pkg::BIT_ANY_READY];
  endproperty
  a_any_clr: assert property (p_any_clr)
    else $error("Combined flags not cleared by read");

  property p_press_ow;
    pressSet && status[sample_status_pkg::BIT_PRESS_READY] && !pressClr
      |=> status[sample_status_pkg::BIT_PRESS_OVERWRITE] ##1
          status[sample_status_pkg::BIT_PRESS_OVERWRITE] || $past(pressClr);
  endproperty
  a_press_ow: assert property (p_press_ow)
    else $error("Pressure overwrite not set");

  property p_press_clr;
    pressHiRead && !pressSet
      |=> !status[sample_status_pkg::BIT_PRESS_READY] &&
          !status[sample_status_pkg::BIT_PRESS_OVERWRITE];
  endproperty
  a_press_clr: assert property (p_press_clr)
    else $error("Pressure flags not cleared");

  property p_temp_ow;
    tempSet && status[sample_status_pkg::BIT_TEMP_READY] && !tempClr
      |=> status[sample_status_pkg::BIT_TEMP_OVERWRITE];
  endproperty
  a_temp_ow: assert property (p_temp_ow)
    else $error("Temperature overwrite not set");

  property p_temp_clr;
    queueRead && !tempSet
      |=> !status[sample_status_pkg::BIT_TEMP_READY] &&
          !status[sample_status_pkg::BIT_TEMP_OVERWRITE];
  endproperty
  a_temp_clr: assert property (p_temp_clr)
    else $error("Temperature flags not cleared by queue read");

  property p_ready_set;
    pressSet || tempSet
      |=> status[sample_status_pkg::BIT_PRESS_READY] || status[sample_status_pkg::BIT_TEMP_READY];
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("Ready flag not set on acquisition");

  property p_any_gate;
    !readyEventGenEnable && !status[sample_status_pkg::BIT_ANY_READY]
      |=> !status[sample_status_pkg::BIT_ANY_READY];
  endproperty
  a_any_gate: assert property (p_any_gate)
    else $error("Combined ready rose while disabled");

  property p_press_gate;
    !pressEventEnable && !status[sample_status_pkg::BIT_PRESS_READY]
      |=> !status[sample_status_pkg::BIT_PRESS_READY];
  endproperty
  a_press_gate: assert property (p_press_gate)
    else $error("Pressure ready rose while disabled");

  property p_press_byte;
    pressHiRead |=> rdData == $past(st_r.pressRes[19:12]);
  endproperty
  a_press_byte: assert property (p_press_byte)
    else $error("Pressure high byte wrong");

  property p_alt_capture;
    pressDone && altimeterMode ##1 !pressDone [*2]
      |-> st_r.pressRes == $past(altitudeSample, 2);
  endproperty
  a_alt_capture: assert property (p_alt_capture)
    else $error("Altitude not captured");

  c_overwrite:  cover property (status[sample_status_pkg::BIT_ANY_OVERWRITE]);
  c_queue_pop:  cover property (queueRead ##1 rdStrobe && queueOn);
  c_burst_wrap: cover property (rdStrobe && (effAddr == sample_status_pkg::ADDR_TEMP_LO));
  c_set_clear:  cover property (pressSet && pressClr);

endmodule

`default_nettype wire

// File: sample_status_pkg.sv
/*
  Shared constants for the per-sample status block: register offsets,
  status bit positions, reset value and queue mode codes.
  Assumes byte-wide registers on an 8-bit register address.
*/
`default_nettype none

package sample_status_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS_ALIAS  = 8'h00;
  localparam logic [7:0] ADDR_PRESS_HI      = 8'h01;
  localparam logic [7:0] ADDR_PRESS_MID     = 8'h02;
  localparam logic [7:0] ADDR_PRESS_LO      = 8'h03;
  localparam logic [7:0] ADDR_TEMP_HI       = 8'h04;
  localparam logic [7:0] ADDR_TEMP_LO       = 8'h05;
  localparam logic [7:0] ADDR_SAMPLE_READY  = 8'h06;
  localparam logic [7:0] ADDR_QUEUE_STATUS  = 8'h0d;
  localparam logic [7:0] ADDR_QUEUE_DATA    = 8'h0e;
  localparam logic [7:0] ADDR_BURST_WRAP    = 8'h05;

  // Status bit positions
  localparam int BIT_ANY_OVERWRITE   = 7;
  localparam int BIT_PRESS_OVERWRITE = 6;
  localparam int BIT_TEMP_OVERWRITE  = 5;
  localparam int BIT_ANY_READY       = 3;
  localparam int BIT_PRESS_READY     = 2;
  localparam int BIT_TEMP_READY      = 1;
  localparam logic [7:0] STATUS_USED_MASK = 8'hee;

  // Values after reset
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  RDDATA_RESET   = 8'h00;
  localparam logic [7:0]  ADDR_RESET     = 8'h00;
  localparam logic [19:0] PRESS_RESET    = 20'h00000;
  localparam logic [11:0] TEMP_RESET     = 12'h000;
  localparam logic [7:0]  UNMAPPED_VALUE = 8'h00;

  // Queue mode field codes
  localparam logic [1:0] QFIELD_OFF       = 2'h0;
  localparam logic [1:0] QFIELD_CIRCULAR  = 2'h1;
  localparam logic [1:0] QFIELD_STOP_FULL = 2'h2;

  typedef enum logic [3:0] {
    QM_OFF       = 4'b0001,
    QM_CIRCULAR  = 4'b0010,
    QM_STOP_FULL = 4'b0100,
    QM_RESERVED  = 4'b1000
  } queue_mode_t;

endpackage

`default_nettype wire

// File: status_flag_bank.sv
/*
  Bank of sticky flags, one per bit: a set pulse raises a flag, a clear
  pulse drops it, and a set in the same cycle as a clear wins.
  Assumes set and clear come from logic on the same clock.
*/
`default_nettype none

module status_flag_bank #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Flag control
  input  wire logic [WIDTH-1:0] setVec,
  input  wire logic [WIDTH-1:0] clrVec,
  // Flag state
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_t;

  bank_t             st_r;
  bank_t             st_nxt;
  logic [WIDTH-1:0]  flagNext;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // Set beats clear so no event is lost
      assign flagNext[i] = setVec[i] | (st_r.flags[i] & ~clrVec[i]);
    end
  endgenerate

  always_comb begin
    st_nxt       = st_r;
    st_nxt.flags = flagNext;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.flags <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;

endmodule

`default_nettype wire

// File: test_sample_status_flags.sv
/*
  Self-checking bench of the per-sample status block.
  Assumes the host reader model for register reads and one clock.
*/
`default_nettype none

module test_sample_status_flags;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        sys_rst;
  wire logic   addrLoad;
  wire logic   rdStrobe;
  wire logic [7:0] addrIn;
  logic [7:0]  rdData;
  logic [7:0]  curAddr;
  logic        pressDone;
  logic        tempDone;
  logic [19:0] pressureSample;
  logic [19:0] altitudeSample;
  logic [11:0] tempSample;
  logic [1:0]  queueModeField;
  logic        altimeterMode;
  logic        readyEventGenEnable;
  logic        pressEventEnable;
  logic        tempEventEnable;
  logic [7:0]  queueStatus;
  logic [7:0]  queueData;
  logic        queuePop;
  logic [7:0]  sampleReadyStatus;
  logic        queueOn;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          pops = 0;

  always #2 clock = ~clock;

  sample_status_flags dut_u (.clock, .sys_rst, .addrLoad, .addrIn, .rdStrobe,
    .rdData, .curAddr, .pressDone, .tempDone, .pressureSample, .altitudeSample,
    .tempSample, .queueModeField, .altimeterMode, .readyEventGenEnable,
    .pressEventEnable, .tempEventEnable, .queueStatus, .queueData, .queuePop,
    .sampleReadyStatus, .queueOn);

  host_reader host_u (.clock, .addrLoad, .addrIn, .rdStrobe, .rdData);

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Tests take under two hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (queuePop === 1'b1) pops++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_u.burst(a, 1);
    check(host_u.got[0], exp);
  endtask

  // Done pulses last one cycle; status is looked at two edges later
  task automatic acq(input logic p, input logic t);
    @(posedge clock);
    pressDone <= p;
    tempDone  <= t;
    @(posedge clock);
    pressDone <= 1'b0;
    tempDone  <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic s_reset;
    check(sampleReadyStatus, 8'h00);
    check(rdData, 8'h00);
    check(curAddr, 8'h00);
  endtask

  task automatic s_flags;
    acq(1'b1, 1'b0);
    check(sampleReadyStatus, 8'h0c);
    acq(1'b0, 1'b1);
    // Combined overwrite: any result while combined ready pending
    check(sampleReadyStatus, 8'h8e);
    acq(1'b1, 1'b0);
    check(sampleReadyStatus, 8'hce);
    acq(1'b0, 1'b1);
    check(sampleReadyStatus, 8'hee);
    rd(8'h06, 8'hee);
    rd(8'h00, 8'hee);
    rd(8'h01, 8'hab);
    check(sampleReadyStatus, 8'h22);
    rd(8'h04, 8'h9a);
    check(sampleReadyStatus, 8'h00);
  endtask

  task automatic s_burst;
    logic [7:0] exp [0:6];
    exp = '{8'h0e, 8'hab, 8'hcd, 8'he0, 8'h9a, 8'h70, 8'h00};
    acq(1'b1, 1'b1);
    host_u.burst(8'h00, 7);
    for (int i = 0; i < 7; i++) check(host_u.got[i], exp[i]);
    check(curAddr, 8'h01);
  endtask

  task automatic s_alt;
    @(posedge clock);
    altimeterMode <= 1'b1;
    acq(1'b1, 1'b0);
    host_u.burst(8'h01, 3);
    check(host_u.got[0], 8'h12);
    check(host_u.got[1], 8'h34);
    check(host_u.got[2], 8'h50);
    check(sampleReadyStatus, 8'h00);
    @(posedge clock);
    altimeterMode <= 1'b0;
  endtask

  // Each enable off in turn: its flags stay low, the other per-sample ready and overwrite flags still rise
  task automatic s_enables;
    logic [7:0] m [0:2];
    m = '{8'h88, 8'h44, 8'h22};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      readyEventGenEnable <= (i != 0);
      pressEventEnable    <= (i != 1);
      tempEventEnable     <= (i != 2);
      acq(1'b1, 1'b1);
      acq(1'b1, 1'b1);
      check(sampleReadyStatus & m[i], 8'h00);
      check(sampleReadyStatus & 8'h66, 8'h66 & ~m[i]);
      rd(8'h01, 8'hab);
      rd(8'h04, 8'h9a);
    end
    @(posedge clock);
    readyEventGenEnable <= 1'b1;
    pressEventEnable    <= 1'b1;
    tempEventEnable     <= 1'b1;
  endtask

  // Read and new sample in one cycle: set wins, no overwrite
  task automatic s_set_clear;
    acq(1'b1, 1'b0);
    check(sampleReadyStatus, 8'h0c);
    fork
      rd(8'h01, 8'hab);
      acq(1'b1, 1'b0);
    join
    check(sampleReadyStatus, 8'h0c);
    rd(8'h01, 8'hab);
    check(sampleReadyStatus, 8'h00);
  endtask

  // Code 11 counts as queue on
  task automatic s_queue;
    logic [1:0] q [0:2];
    q = '{2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      queueModeField <= q[i];
      acq(1'b1, 1'b1);
      check({7'h00, queueOn}, 8'h01);
      pops = 0;
      host_u.burst(8'h00, 3);
      check(host_u.got[0], 8'h5a);
      check(host_u.got[1], 8'h3c);
      check(host_u.got[2], 8'h3c);
      check(pops[7:0], 8'h02);
      check(sampleReadyStatus, 8'h00);
      rd(8'h02, 8'h00);
    end
    @(posedge clock);
    queueModeField <= 2'h0;
    @(posedge clock);
    #1 check({7'h00, queueOn}, 8'h00);
  endtask

  task automatic s_unmapped;
    rd(8'h07, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h0d, 8'h5a);
    rd(8'h0e, 8'h3c);
  endtask

  // Reset in mid-run drops flags, pointer and read byte
  task automatic s_mid_reset;
    acq(1'b1, 1'b1);
    rd(8'h02, 8'hcd);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    s_reset;
  endtask

  initial begin
    sys_rst             = 1'b1;
    pressDone           = 1'b0;
    tempDone            = 1'b0;
    pressureSample      = 20'habcde;
    altitudeSample      = 20'h12345;
    tempSample          = 12'h9a7;
    queueModeField      = 2'h0;
    altimeterMode       = 1'b0;
    readyEventGenEnable = 1'b1;
    pressEventEnable    = 1'b1;
    tempEventEnable     = 1'b1;
    queueStatus         = 8'h5a;
    queueData           = 8'h3c;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    s_reset;
    s_flags;
    s_burst;
    s_alt;
    s_enables;
    s_set_clear;
    s_queue;
    s_unmapped;
    s_mid_reset;
    report_and_stop;
  end
endmodule

`default_nettype wire
